// *** bench/pssg_assertions.sv ***
/*
  Checker of the single stroke guard on the top ports only.
  Assumes a bind to pssg_guard and the three-edge input latency.
*/
`timescale 1ns/100ps
module pssg_assertions #(
  parameter int unsigned TICK_CYCLES = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic on_start,
  input wire logic static_permit,
  input wire logic start_permit,
  input wire logic safety_permit,
  input wire logic upper_reversal_point,
  input wire logic restart_req,
  input wire logic release_o,
  input wire logic restart_pending
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_excl;
    !(release_o && restart_pending);
  endproperty
  a_excl: assert property (p_excl) else $error("release with pending");
  property p_rst_quiet;
    $rose(presetn) |-> !release_o && !restart_pending;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs up at reset");
  property p_armed_start;
    $rose(presetn) && static_permit |-> ##[2:8] restart_pending;
  endproperty
  a_armed_start: assert property (p_armed_start) else $error("not armed");
  property p_top_drop;
    $rose(upper_reversal_point) |-> ##[1:4] !release_o;
  endproperty
  a_top_drop: assert property (p_top_drop) else $error("no drop at top");
  property p_start_cause;
    $rose(release_o) |-> $past(on_start, 3) && $past(static_permit, 3);
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("bad start");
  property p_start_edge;
    $rose(release_o) |-> !$past(on_start, 4);
  endproperty
  a_start_edge: assert property (p_start_edge) else $error("start w/o edge");
  property p_static_drop;
    $fell(static_permit) |-> ##[1:4] !release_o;
  endproperty
  a_static_drop: assert property (p_static_drop) else $error("no permit stop");
  // while all permits stay high, pending may only clear once the restart input has fallen
  property p_pend_hold;
    restart_pending && restart_req && static_permit && start_permit && safety_permit
      |=> restart_pending;
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("early clear");
  c_start: cover property ($rose(release_o));
  c_restart: cover property ($fell(restart_pending));
  c_top: cover property ($rose(upper_reversal_point));
endmodule // pssg_assertions

// *** bench/pssg_press_model.sv ***
/*
  Press contact model: the ram steps once a cycle while released.
  Assumes release_o from the guard; a stop freezes the ram in place.
*/
`timescale 1ns/100ps
module pssg_press_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic release_o,
  input wire logic slow,
  output logic upper_reversal_point,
  output logic upstroke_contact
);
  logic [12:0] pos_r;
  logic done_r;
  logic [12:0] len;
  // ----------------------------------------
  // ram motion
  // ----------------------------------------
  assign len = slow ? 13'h1800 : 13'h0040;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_r <= '0;
      done_r <= 1'b0;
    end else if (!release_o) begin
      done_r <= 1'b0;
    end else if (!done_r) begin
      // parked at the top until the release drops
      pos_r <= (pos_r == len - 13'h0001) ? '0 : pos_r + 13'h0001;
      done_r <= (pos_r == len - 13'h0001);
    end
  end
  assign upper_reversal_point = (pos_r == '0);
  assign upstroke_contact = (pos_r >= (len >> 1));
endmodule // pssg_press_model

// *** bench/tb_top.sv ***
/*
  Testbench of the single stroke guard: reset, interlock, inching,
  single start, muting and APB access.
  Assumes the millisecond tick is cut to two clocks.
*/
`timescale 1ns/100ps
`include "pssg_params.svh"
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, serr, release_o, restart_pending, irq, top, ups;
  logic on_start = 1'b0, static_permit = 1'b1, start_permit = 1'b1;
  logic safety_permit = 1'b1, restart_req = 1'b0, slow = 1'b0;
  int err_count = 0;
  int samples_checked = 0;
  pssg_guard #(.TICK_CYCLES(2)) u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .on_start(on_start), .static_permit(static_permit),
    .start_permit(start_permit), .safety_permit(safety_permit),
    .upper_reversal_point(top), .upstroke_contact(ups), .restart_req(restart_req),
    .release_o(release_o), .restart_pending(restart_pending), .irq(irq));
  pssg_press_model u_press (.pclk(pclk), .presetn(presetn), .release_o(release_o),
    .slow(slow), .upper_reversal_point(top), .upstroke_contact(ups));
  initial forever #4 pclk = ~pclk;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task wt(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  // selector instead of a ref argument: free simulators handle it poorly
  task automatic wait_for(input bit use_ups, input logic v);
    for (int i = 0; i < 20000 && (use_ups ? ups : release_o) !== v; i++) @(negedge pclk);
    chk(use_ups ? ups : release_o, v);
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task pulse(input int n);
    @(posedge pclk) restart_req <= 1'b1;
    repeat (n) @(posedge pclk);
    restart_req <= 1'b0;
    wt(12);
  endtask
  task start(input logic v);
    @(posedge pclk) on_start <= v;
    wt(6);
  endtask
  task print_verdict;
    $display("mismatches %0d of %0d checks", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    wt(8);
    chk(release_o, 1'b0);
    chk(restart_pending, 1'b1);
    apb(1'b0, `PSSG_OFS_CFG, '0);
    chk(rd, 32'h0001_05C2);
    apb(1'b0, 8'h14, '0);
    chk(serr, 1'b1);
    apb(1'b1, `PSSG_OFS_STAT, '1);
    apb(1'b0, `PSSG_OFS_STAT, '0);
    chk(rd[10:8], 3'b110);
  endtask
  task t_interlock;
    start(1'b1);
    chk(release_o, 1'b0);
    start(1'b0);
    pulse(100);
    chk(restart_pending, 1'b1);
    pulse(240);
    chk(restart_pending, 1'b0);
    start(1'b1);
    chk(release_o, 1'b1);
    wait_for(1'b0, 1'b0);
    chk(top, 1'b1);
    wt(4);
    chk(restart_pending, 1'b1);
    start(1'b0);
    apb(1'b1, `PSSG_OFS_CFG, 32'h0001_15C2);
    pulse(500);
    chk(restart_pending, 1'b1);
    pulse(760);
    chk(restart_pending, 1'b0);
  endtask
  task t_inching;
    apb(1'b1, `PSSG_OFS_CFG, 32'h0001_05C1);
    apb(1'b1, `PSSG_OFS_IRQ_CLR, 32'h0000_001F);
    apb(1'b1, `PSSG_OFS_IRQ_EN, 32'h0000_0001);
    @(posedge pclk) slow <= 1'b1;
    start(1'b1);
    chk(release_o, 1'b1);
    chk(irq, 1'b1);
    apb(1'b1, `PSSG_OFS_IRQ_CLR, 32'h0000_001F);
    wt(1);
    chk(irq, 1'b0);
    start(1'b0);
    chk(release_o, 1'b0);
    chk(restart_pending, 1'b0);
    start(1'b1);
    chk(release_o, 1'b1);
    @(posedge pclk) static_permit <= 1'b0;
    wt(6);
    chk(release_o, 1'b0);
    @(posedge pclk) static_permit <= 1'b1;
    on_start <= 1'b0;
  endtask
  task t_single;
    apb(1'b1, `PSSG_OFS_CFG, 32'h0001_06C1);
    start(1'b1);
    start(1'b0);
    chk(release_o, 1'b1);
    wait_for(1'b0, 1'b0);
    chk(top, 1'b1);
  endtask
  task t_muting;
    apb(1'b1, `PSSG_OFS_CFG, 32'h0001_09F1);
    start(1'b1);
    chk(release_o, 1'b1);
    wait_for(1'b1, 1'b1);
    @(posedge pclk) safety_permit <= 1'b0;
    wt(20);
    chk(release_o, 1'b1);
    wt(2100);
    chk(release_o, 1'b0);
    @(posedge pclk) safety_permit <= 1'b1;
    on_start <= 1'b0;
  endtask
  task t_modes;
    apb(1'b1, `PSSG_OFS_CFG, 32'h0001_05C3);
    start(1'b1);
    chk(release_o, 1'b1);
    start(1'b0);
    chk(restart_pending, 1'b1);
    pulse(240);
    chk(restart_pending, 1'b0);
    apb(1'b1, `PSSG_OFS_CFG, 32'h0001_05C5);
    start(1'b1);
    start(1'b0);
    chk({release_o, restart_pending}, 2'b00);
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_interlock;
    t_inching;
    t_single;
    t_muting;
    t_modes;
    print_verdict;
  end
  // whole run needs about 13500 cycles
  initial begin
    repeat (40000) @(posedge pclk);
    err_count++;
    print_verdict;
  end
endmodule // tb_top

bind pssg_guard pssg_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_assert (.pclk(pclk),
  .presetn(presetn), .on_start(on_start), .static_permit(static_permit),
  .start_permit(start_permit), .safety_permit(safety_permit),
  .upper_reversal_point(upper_reversal_point), .restart_req(restart_req),
  .release_o(release_o), .restart_pending(restart_pending));

// *** common/pssg_params.svh ***
/*
  Constants of the press single stroke guard: clock rate, timing figures,
  register offsets, field positions and reset values.
  Assumes inclusion by bare name from the testbench and the design modules.
*/
`ifndef PSSG_PARAMS_SVH
`define PSSG_PARAMS_SVH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define PSSG_CLK_HZ 125000000
`define PSSG_MS_PER_S 1000
`define PSSG_MS_CYCLES (`PSSG_CLK_HZ / `PSSG_MS_PER_S)
`define PSSG_MIN_PULSE_SHORT_MS 100
`define PSSG_MIN_PULSE_LONG_MS 350
`define PSSG_MAX_PULSE_S 30
`define PSSG_MAX_PULSE_MS (`PSSG_MAX_PULSE_S * `PSSG_MS_PER_S)
`define PSSG_MUTE_MIN_S 1
`define PSSG_MUTE_MAX_S 7200

// ----------------------------------------------------------------------
// synchronised input vector positions
// ----------------------------------------------------------------------
`define PSSG_IN_ONS 0
`define PSSG_IN_STAT 1
`define PSSG_IN_STRT 2
`define PSSG_IN_SAFE 3
`define PSSG_IN_URP 4
`define PSSG_IN_UPS 5
`define PSSG_IN_RST 6
`define PSSG_IN_W 7

// ----------------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------------
`define PSSG_ADDR_W 8
`define PSSG_OFS_CFG 8'h00
`define PSSG_OFS_STAT 8'h04
`define PSSG_OFS_IRQ_STS 8'h08
`define PSSG_OFS_IRQ_CLR 8'h0C
`define PSSG_OFS_IRQ_EN 8'h10

// ----------------------------------------------------------------------
// configuration fields
// ----------------------------------------------------------------------
`define PSSG_CFG_ILK_MSB 2
`define PSSG_CFG_ILK_LSB 0
`define PSSG_CFG_STRT_EN 3
`define PSSG_CFG_SAFE_EN 4
`define PSSG_CFG_UPS_EN 5
`define PSSG_CFG_RST_EN 6
`define PSSG_CFG_PEND_EN 7
`define PSSG_CFG_SMODE_MSB 9
`define PSSG_CFG_SMODE_LSB 8
`define PSSG_CFG_MMODE_MSB 11
`define PSSG_CFG_MMODE_LSB 10
`define PSSG_CFG_MIN_LONG 12
`define PSSG_CFG_TDC_DESEL 13
`define PSSG_CFG_MAXS_MSB 28
`define PSSG_CFG_MAXS_LSB 16
`define PSSG_CFG_MASK 32'h1FFF_3FFF
`define PSSG_CFG_RST 32'h0001_05C2

// mode encodings
`define PSSG_ILK_NONE 3'h1
`define PSSG_ILK_ALWAYS 3'h2
`define PSSG_ILK_ONS 3'h3
`define PSSG_ILK_TOP 3'h4
`define PSSG_ILK_PERM 3'h5
`define PSSG_SMODE_SINGLE 2'h2
`define PSSG_MMODE_SAFE 2'h2
`define PSSG_MMODE_BOTH 2'h3

// status and interrupt bits
`define PSSG_STAT_REL 8
`define PSSG_STAT_ARMED 9
`define PSSG_STAT_PEND 10
`define PSSG_STAT_MUTE 11
`define PSSG_IRQ_W 5
`define PSSG_IRQ_START 0
`define PSSG_IRQ_STOP 1
`define PSSG_IRQ_ARM 2
`define PSSG_IRQ_RESTART 3
`define PSSG_IRQ_MUTE_TO 4

`endif

// *** common/pssg_pkg.sv ***
/*
  Types of the press single stroke guard: the state record of each module.
  Assumes the constants header is on the include path.
*/
package pssg_pkg;

  typedef struct packed {
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic [6:0] prev;
    logic [16:0] tick_cnt;
    logic ms_tick;
    logic release_on;
    logic armed;
    logic pending;
    logic mute_prev;
    logic [31:0] cfg;
    logic [4:0] irq_sts;
    logic [4:0] irq_en;
    logic [31:0] rdata;
  } pssg_top_st_t;

  typedef struct packed {
    logic lvl_prev;
    logic ok;
    logic [14:0] hi_ms;
  } pssg_chk_st_t;

  typedef struct packed {
    logic up_prev;
    logic active;
    logic [9:0] ms_cnt;
    logic [12:0] s_cnt;
  } pssg_mute_st_t;

endpackage

// *** common/pssg_sub_if.sv ***
/*
  Carrier between the guard core and its two timers.
  Assumes all signals live in the pclk domain.
*/
`timescale 1ns/100ps
interface pssg_sub_if;
  logic ms_tick;
  logic restart_lvl;
  logic min_long;
  logic restart_ok;
  logic upstroke_lvl;
  logic mute_en;
  logic [12:0] mute_max_s;
  logic muting;

  modport chk (input ms_tick, input restart_lvl, input min_long, output restart_ok);
  modport mute (input ms_tick, input upstroke_lvl, input mute_en, input mute_max_s,
                output muting);
  modport ctl (output ms_tick, output restart_lvl, output min_long, output upstroke_lvl,
               output mute_en, output mute_max_s, input restart_ok, input muting);
endinterface // pssg_sub_if

// *** core/pssg_guard.sv ***
/*
  Press single stroke guard: grants the press release for one stroke,
  drops it at the upper reversal point, keeps a configurable restart
  interlock and mutes the safety permit during the upstroke. Registers over APB.
  Assumes the guard inputs come from logic outside pclk's domain and that
  the contact monitor raises the reversal point input on each return.
*/
`timescale 1ns/100ps
`include "pssg_params.svh"

// Behaviour
// - rising start command requests a start, falling edge requests a stop.
// - release rises on start edge with static permit high and no pending restart.
// - every rising edge of the reversal point input drops release.
// - interlock mode picks none, always, on-start, top, or permit conditions.
// - optional permit, contact, restart inputs and pending output ignored when off.
// - start mode picks jog (1) or one-shot single stroke start (2).
// - upstroke muting covers nothing, safety permit, or safety permit and start.
// - muting lasts at most a configured 1 to 7200 seconds.
// - minimum restart pulse is 100 ms or 350 ms.
// - deselect option: safety permit fall at the reversal point does not arm.
// - pending output shows an armed interlock that needs a restart.
// - after a drop at the reversal point a new start edge starts again, except in always and top modes, which arm.
// - restart pulse counts only if high phase is within minimum and 30 seconds.
// - always mode starts armed and arms on every stop except a deselected safety permit fall at the reversal point.
// - when muting times out a low muted input drops release.
// - one-shot mode ignores a falling start command once started.
module pssg_guard #(
  parameter int unsigned TICK_CYCLES = `PSSG_MS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic on_start,
  input wire logic static_permit,
  input wire logic start_permit,
  input wire logic safety_permit,
  input wire logic upper_reversal_point,
  input wire logic upstroke_contact,
  input wire logic restart_req,
  output logic release_o,
  output logic restart_pending,
  output logic irq
);

  // ----------------------------------------------------------------------
  // constants and state
  // ----------------------------------------------------------------------
  localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);
  localparam logic [12:0] MUTE_MIN = 13'(`PSSG_MUTE_MIN_S);
  localparam logic [12:0] MUTE_MAX = 13'(`PSSG_MUTE_MAX_S);
  // armed from reset: an interlocked press never starts before a restart
  localparam pssg_pkg::pssg_top_st_t ST_RST = '{
    armed: 1'b1,
    cfg: `PSSG_CFG_RST,
    default: '0
  };

  pssg_pkg::pssg_top_st_t st_r;
  pssg_pkg::pssg_top_st_t st_nxt;
  pssg_sub_if sub ();

  logic [6:0] pins;
  logic [6:0] lvl;
  logic [6:0] rise;
  logic [6:0] fall;
  logic [2:0] ilk_mode;
  logic [1:0] mute_mode;
  logic [12:0] maxs_raw;
  logic ilk_on;
  logic single_mode;
  logic start_ok;
  logic safe_lvl;
  logic mute_safe;
  logic mute_ons;
  logic mute_end;
  logic stop_top;
  logic stop_ons;
  logic stop_stat;
  logic stop_safe;
  logic stop_any;
  logic arm_evt;
  logic start_evt;
  logic precond;
  logic acc;
  logic setup;
  logic mapped;
  logic [4:0] irq_evt;
  logic [4:0] irq_clr;

  // ----------------------------------------------------------------------
  // decoded configuration
  // ----------------------------------------------------------------------
  assign ilk_mode = st_r.cfg[`PSSG_CFG_ILK_MSB:`PSSG_CFG_ILK_LSB];
  assign mute_mode = st_r.cfg[`PSSG_CFG_MMODE_MSB:`PSSG_CFG_MMODE_LSB];
  assign maxs_raw = st_r.cfg[`PSSG_CFG_MAXS_MSB:`PSSG_CFG_MAXS_LSB];
  assign ilk_on = (ilk_mode != `PSSG_ILK_NONE);
  assign single_mode =
    (st_r.cfg[`PSSG_CFG_SMODE_MSB:`PSSG_CFG_SMODE_LSB] == `PSSG_SMODE_SINGLE);

  // ----------------------------------------------------------------------
  // input sampling
  // ----------------------------------------------------------------------
  assign pins = {restart_req, upstroke_contact, upper_reversal_point, safety_permit,
                 start_permit, static_permit, on_start};
  assign lvl = st_r.sync2;
  assign rise = st_r.sync2 & ~st_r.prev;
  assign fall = ~st_r.sync2 & st_r.prev;

  // disabled optional inputs read as permanently satisfied or idle
  assign start_ok = !st_r.cfg[`PSSG_CFG_STRT_EN] || lvl[`PSSG_IN_STRT];
  assign safe_lvl = !st_r.cfg[`PSSG_CFG_SAFE_EN] || lvl[`PSSG_IN_SAFE];
  assign precond = lvl[`PSSG_IN_STAT] && start_ok && safe_lvl;

  // ----------------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------------
  assign sub.ms_tick = st_r.ms_tick;
  assign sub.restart_lvl = st_r.cfg[`PSSG_CFG_RST_EN] && lvl[`PSSG_IN_RST];
  assign sub.min_long = st_r.cfg[`PSSG_CFG_MIN_LONG];
  assign sub.upstroke_lvl = st_r.cfg[`PSSG_CFG_UPS_EN] && lvl[`PSSG_IN_UPS];
  assign sub.mute_en = (mute_mode == `PSSG_MMODE_SAFE) || (mute_mode == `PSSG_MMODE_BOTH);
  // a zero or oversized setting is held inside the legal range
  assign sub.mute_max_s = (maxs_raw < MUTE_MIN) ? MUTE_MIN :
                          (maxs_raw > MUTE_MAX) ? MUTE_MAX : maxs_raw;

  pssg_restart_chk u_chk (
    .pclk(pclk),
    .presetn(presetn),
    .sub(sub.chk)
  );

  pssg_mute_timer u_mute (
    .pclk(pclk),
    .presetn(presetn),
    .sub(sub.mute)
  );

  // ----------------------------------------------------------------------
  // stop causes
  // ----------------------------------------------------------------------
  assign mute_safe = sub.muting;
  assign mute_ons = sub.muting && (mute_mode == `PSSG_MMODE_BOTH);
  assign mute_end = st_r.mute_prev && !sub.muting;

  // the reversal point input must drop mid-stroke for this edge to come back
  assign stop_top = rise[`PSSG_IN_URP];
  assign stop_ons = !single_mode &&
    ((fall[`PSSG_IN_ONS] && !mute_ons) ||
     (mute_end && mute_mode == `PSSG_MMODE_BOTH && !lvl[`PSSG_IN_ONS]));
  assign stop_stat = !lvl[`PSSG_IN_STAT];
  // a low permit after muting ends is a level, so it stops at once
  assign stop_safe = !safe_lvl && !mute_safe;
  assign stop_any = st_r.release_on && (stop_top || stop_ons || stop_stat || stop_safe);

  // ----------------------------------------------------------------------
  // interlock arming
  // ----------------------------------------------------------------------
  always_comb begin
    logic perm;
    perm = stop_stat ||
           (stop_safe && !(st_r.cfg[`PSSG_CFG_TDC_DESEL] && lvl[`PSSG_IN_URP]));
    arm_evt = 1'b0;
    if (st_r.release_on) begin
      unique case (ilk_mode)
        `PSSG_ILK_NONE: arm_evt = 1'b0;
        `PSSG_ILK_ONS: arm_evt = stop_ons || perm;
        `PSSG_ILK_TOP: arm_evt = stop_top || perm;
        `PSSG_ILK_PERM: arm_evt = perm;
        // unused codes fall back to the strictest setting
        default: arm_evt = stop_top || stop_ons || perm;
      endcase
    end
  end

  assign start_evt = !st_r.release_on && rise[`PSSG_IN_ONS] && precond &&
                     !(st_r.armed && ilk_on);

  // ----------------------------------------------------------------------
  // register bus decode
  // ----------------------------------------------------------------------
  assign setup = psel && !penable;
  assign acc = psel && penable;
  assign mapped = (paddr == `PSSG_OFS_CFG) || (paddr == `PSSG_OFS_STAT) ||
                  (paddr == `PSSG_OFS_IRQ_STS) || (paddr == `PSSG_OFS_IRQ_CLR) ||
                  (paddr == `PSSG_OFS_IRQ_EN);
  assign irq_clr = (acc && pwrite && paddr == `PSSG_OFS_IRQ_CLR) ? pwdata[4:0] : 5'h00;

  always_comb begin
    irq_evt = '0;
    irq_evt[`PSSG_IRQ_START] = start_evt;
    irq_evt[`PSSG_IRQ_STOP] = stop_any;
    irq_evt[`PSSG_IRQ_ARM] = arm_evt && ilk_on;
    irq_evt[`PSSG_IRQ_RESTART] = sub.restart_ok && st_r.armed && ilk_on;
    irq_evt[`PSSG_IRQ_MUTE_TO] = mute_end && sub.upstroke_lvl;
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = pins;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev = st_r.sync2;
    st_nxt.mute_prev = sub.muting;

    if (st_r.tick_cnt == TICK_LAST) begin
      st_nxt.tick_cnt = '0;
      st_nxt.ms_tick = 1'b1;
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + 17'h0_0001;
      st_nxt.ms_tick = 1'b0;
    end

    // arming wins over a restart accepted in the same cycle
    st_nxt.armed = ilk_on && (arm_evt || (st_r.armed && !sub.restart_ok));

    if (st_r.release_on) begin
      st_nxt.release_on = !stop_any;
    end else begin
      st_nxt.release_on = start_evt;
    end

    st_nxt.pending = st_r.cfg[`PSSG_CFG_PEND_EN] && st_nxt.armed && precond;

    if (acc && pwrite && paddr == `PSSG_OFS_CFG) begin
      st_nxt.cfg = pwdata & `PSSG_CFG_MASK;
    end
    if (acc && pwrite && paddr == `PSSG_OFS_IRQ_EN) begin
      st_nxt.irq_en = pwdata[4:0];
    end
    st_nxt.irq_sts = (st_r.irq_sts & ~irq_clr) | irq_evt;

    // read data is caught in the setup cycle so prdata leaves a flop
    if (setup && !pwrite) begin
      st_nxt.rdata = '0;
      unique case (paddr)
        `PSSG_OFS_CFG: st_nxt.rdata = st_r.cfg;
        `PSSG_OFS_STAT: begin
          st_nxt.rdata[6:0] = lvl;
          st_nxt.rdata[`PSSG_STAT_REL] = st_r.release_on;
          st_nxt.rdata[`PSSG_STAT_ARMED] = st_r.armed && ilk_on;
          st_nxt.rdata[`PSSG_STAT_PEND] = st_r.pending;
          st_nxt.rdata[`PSSG_STAT_MUTE] = sub.muting;
        end
        `PSSG_OFS_IRQ_STS: st_nxt.rdata[4:0] = st_r.irq_sts;
        `PSSG_OFS_IRQ_EN: st_nxt.rdata[4:0] = st_r.irq_en;
        default: st_nxt.rdata = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // release only rises when not armed and clears in the cycle arming sets
  assign release_o = st_r.release_on;
  assign restart_pending = st_r.pending;
  assign irq = |(st_r.irq_sts & st_r.irq_en);
  assign prdata = st_r.rdata;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;

endmodule // pssg_guard

// *** core/pssg_mute_timer.sv ***
/*
  Upstroke muting timer: muting starts on the rising edge of the upstroke
  contact and ends on its fall or after the configured whole seconds.
  Assumes a synchronised contact level and a one-cycle millisecond tick.
*/
`timescale 1ns/100ps
`include "pssg_params.svh"
module pssg_mute_timer (
  input wire logic pclk,
  input wire logic presetn,
  pssg_sub_if.mute sub
);

  localparam logic [9:0] MS_LAST = 10'(`PSSG_MS_PER_S - 1);

  pssg_pkg::pssg_mute_st_t st_r;
  pssg_pkg::pssg_mute_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.up_prev = sub.upstroke_lvl;
    if (!sub.mute_en || !sub.upstroke_lvl) begin
      st_nxt.active = 1'b0;
    end else if (!st_r.up_prev) begin
      st_nxt.active = 1'b1;
      st_nxt.ms_cnt = '0;
      st_nxt.s_cnt = '0;
    end else if (st_r.active && sub.ms_tick) begin
      if (st_r.ms_cnt == MS_LAST) begin
        st_nxt.ms_cnt = '0;
        st_nxt.s_cnt = st_r.s_cnt + 13'h0001;
        if (st_r.s_cnt + 13'h0001 >= sub.mute_max_s) begin
          st_nxt.active = 1'b0;
        end
      end else begin
        st_nxt.ms_cnt = st_r.ms_cnt + 10'h001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sub.muting = st_r.active;

endmodule // pssg_mute_timer

// *** core/pssg_restart_chk.sv ***
/*
  Restart pulse checker: flags a low-high-low pulse whose high phase lies
  between the selected minimum and the upper limit, in millisecond ticks.
  Assumes a synchronised level and a one-cycle millisecond tick.
*/
`timescale 1ns/100ps
`include "pssg_params.svh"
module pssg_restart_chk (
  input wire logic pclk,
  input wire logic presetn,
  pssg_sub_if.chk sub
);

  localparam logic [14:0] MAX_MS = 15'(`PSSG_MAX_PULSE_MS);
  localparam logic [14:0] SHORT_MS = 15'(`PSSG_MIN_PULSE_SHORT_MS);
  localparam logic [14:0] LONG_MS = 15'(`PSSG_MIN_PULSE_LONG_MS);

  pssg_pkg::pssg_chk_st_t st_r;
  pssg_pkg::pssg_chk_st_t st_nxt;
  logic [14:0] min_ms;

  assign min_ms = sub.min_long ? LONG_MS : SHORT_MS;

  always_comb begin
    st_nxt = st_r;
    st_nxt.ok = 1'b0;
    st_nxt.lvl_prev = sub.restart_lvl;
    if (sub.restart_lvl) begin
      if (!st_r.lvl_prev) begin
        st_nxt.hi_ms = '0;
      end else if (sub.ms_tick && st_r.hi_ms <= MAX_MS) begin
        // saturates one past the limit so an over-long pulse stays rejected
        st_nxt.hi_ms = st_r.hi_ms + 15'h0001;
      end
    end else if (st_r.lvl_prev) begin
      st_nxt.ok = (st_r.hi_ms >= min_ms) && (st_r.hi_ms <= MAX_MS);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sub.restart_ok = st_r.ok;

endmodule // pssg_restart_chk
